// file: core/scr_pkg.sv
// Constants, field layout and types shared by the system clock control register block
package scr_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int IDX_W = 6;
  localparam int ADDR_W = IDX_W + 2;
  localparam int BUS_W = 32;
  localparam int BE_W = BUS_W / 8;
  localparam int REG_W = 8;
  localparam logic [1:0] WORD_ALIGNED = 2'h0;

  // ---------------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] SYS_CLK_CTRL_IDX = 6'h1c;
  localparam logic [IDX_W-1:0] TBL_HIGH_PTR_IDX = 6'h1f;

  // ---------------------------------------------------------------------------
  // Clock control fields
  // ---------------------------------------------------------------------------
  localparam int BIT_SERIAL_CLK_EN = 3;
  localparam int BIT_MINUS_PULLUP = 4;
  localparam int BIT_RATE_SELECT = 6;
  localparam int BIT_LEGACY_MODE = 7;
  localparam logic [REG_W-1:0] CTRL_SPARE_MASK = 8'h27;
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;

  // ---------------------------------------------------------------------------
  // Table read pointer fields
  // ---------------------------------------------------------------------------
  localparam int PROG_W = 14;
  localparam int TBL_PTR_W = 3;
  localparam int TBL_PROG_LSB = 8;
  localparam logic [TBL_PTR_W-1:0] TBL_PTR_RESET = 3'h0;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [0:0] {
    SCR_RATE_12MHZ = 1'b0,
    SCR_RATE_6MHZ = 1'b1
  } scr_rate_t;

  typedef enum logic [0:0] {
    SCR_BUS_IDLE = 1'b0,
    SCR_BUS_ANSWER = 1'b1
  } scr_bus_state_t;

endpackage

// file: core/scr_reg_if.sv
// Decoded register access between the bus slave and the register core
`timescale 1ns/1ns
interface scr_reg_if;
  logic [scr_pkg::IDX_W-1:0] index;
  logic hit;
  logic wr_pulse;
  logic [scr_pkg::REG_W-1:0] wdata;
  logic [scr_pkg::REG_W-1:0] rdata;

  modport bus_end (
    output index,
    output hit,
    output wr_pulse,
    output wdata,
    input rdata
  );

  modport reg_end (
    input index,
    input hit,
    input wr_pulse,
    input wdata,
    output rdata
  );
endinterface

// file: core/scr_avalon_slave.sv
// Avalon-MM slave front end with one wait state for every access while clk_en stays high
`timescale 1ns/1ns
module scr_avalon_slave (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [scr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [scr_pkg::BUS_W-1:0] avs_writedata,
  input wire logic [scr_pkg::BE_W-1:0] avs_byteenable,
  output logic [scr_pkg::BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  scr_reg_if.bus_end regs
);

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  logic request;
  logic answering;
  scr_pkg::scr_bus_state_t state_q;
  scr_pkg::scr_bus_state_t state_d;
  logic [scr_pkg::BUS_W-1:0] readdata_q;
  logic [scr_pkg::BUS_W-1:0] readdata_d;

  assign request = avs_read | avs_write;
  assign answering = (state_q == scr_pkg::SCR_BUS_ANSWER) && clk_en;
  assign regs.index = avs_address[scr_pkg::ADDR_W-1:2];
  // Misaligned byte addresses map to nothing
  assign regs.hit = (avs_address[1:0] == scr_pkg::WORD_ALIGNED);
  assign regs.wdata = avs_writedata[scr_pkg::REG_W-1:0];
  // Only lane 0 carries register bits; a write without it is accepted and dropped
  assign regs.wr_pulse = answering && avs_write && avs_byteenable[0];
  // Held high while frozen so the master never completes an uncommitted access
  assign avs_waitrequest = ~answering;
  assign avs_readdata = readdata_q;

  // ---------------------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    readdata_d = readdata_q;
    case (state_q)
      scr_pkg::SCR_BUS_IDLE: begin
        if (request) begin
          state_d = scr_pkg::SCR_BUS_ANSWER;
          if (avs_read) begin
            readdata_d = {{(scr_pkg::BUS_W - scr_pkg::REG_W){1'b0}}, regs.rdata};
          end
        end
      end
      scr_pkg::SCR_BUS_ANSWER: begin
        state_d = scr_pkg::SCR_BUS_IDLE;
      end
      default: begin
        state_d = scr_pkg::SCR_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= scr_pkg::SCR_BUS_IDLE;
      readdata_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      readdata_q <= readdata_d;
    end
  end

endmodule // scr_avalon_slave

// file: core/scr_system_clock_ctrl.sv
// System clock control and table read high pointer registers behind an Avalon-MM slave
//
// Functional notes
// (RULE1) Clock control byte at index 0x1c, read/write
// (RULE2) Bit 3 runs engine clock, resets off
// (RULE3) Bit 4 connects minus line pull-up, resets off
// (RULE4) Bit 6 picks 12 MHz or 6 MHz
// (RULE5) Bit 7 firmware legacy mouse flag, reset clears
// (RULE6) Index 0x1f returns last table read bits 10:8
// (RULE7) Spare bits store and read back only
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module scr_system_clock_ctrl #(
  parameter bit TBL_PTR_ENABLE = 1'b1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [scr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [scr_pkg::BUS_W-1:0] avs_writedata,
  input wire logic [scr_pkg::BE_W-1:0] avs_byteenable,
  output logic [scr_pkg::BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic table_read_valid,
  input wire logic [scr_pkg::PROG_W-1:0] table_read_word,
  output logic serial_bus_clock_enable,
  output logic minus_line_pullup_enable,
  output logic system_clock_rate_select,
  output logic legacy_mouse_mode_flag
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------

  // True when the decoded access addresses the given register
  function automatic logic reg_selected(
    input logic hit,
    input logic [scr_pkg::IDX_W-1:0] index,
    input logic [scr_pkg::IDX_W-1:0] target
  );
    reg_selected = hit && (index == target);
  endfunction

  // Upper program-word bits that a table read leaves behind
  function automatic logic [scr_pkg::TBL_PTR_W-1:0] high_bits(
    input logic [scr_pkg::PROG_W-1:0] word
  );
    high_bits = word[scr_pkg::TBL_PROG_LSB +: scr_pkg::TBL_PTR_W];
  endfunction

  // Pointer zero-extended to the register width
  function automatic logic [scr_pkg::REG_W-1:0] widen_ptr(
    input logic [scr_pkg::TBL_PTR_W-1:0] ptr
  );
    widen_ptr = {{(scr_pkg::REG_W - scr_pkg::TBL_PTR_W){1'b0}}, ptr};
  endfunction

  // ---------------------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------------------
  scr_reg_if regs ();

  scr_avalon_slave u_slave (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .regs(regs.bus_end)
  );

  logic ctrl_sel;
  logic ptr_sel;

  assign ctrl_sel = reg_selected(regs.hit, regs.index, scr_pkg::SYS_CLK_CTRL_IDX); // see (RULE1)
  assign ptr_sel = reg_selected(regs.hit, regs.index, scr_pkg::TBL_HIGH_PTR_IDX); // see (RULE6)

  // ---------------------------------------------------------------------------
  // Clock control register
  // ---------------------------------------------------------------------------
  logic [scr_pkg::REG_W-1:0] ctrl_q;
  logic [scr_pkg::REG_W-1:0] ctrl_d;

  // Every bit is plainly writable, spare bits included, so firmware sees its own value back
  always_comb begin
    ctrl_d = ctrl_q;
    if (regs.wr_pulse && ctrl_sel) begin
      ctrl_d = regs.wdata; // see (RULE1) see (RULE7)
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= scr_pkg::CTRL_RESET; // see (RULE2) see (RULE3) see (RULE4) see (RULE5) see (RULE7)
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Table read high pointer
  // ---------------------------------------------------------------------------
  logic [scr_pkg::TBL_PTR_W-1:0] tbl_ptr_q;
  logic [scr_pkg::TBL_PTR_W-1:0] tbl_ptr_d;

  // Bus writes to the pointer are ignored; only a table read moves it
  always_comb begin
    tbl_ptr_d = tbl_ptr_q;
    if (TBL_PTR_ENABLE && table_read_valid) begin
      tbl_ptr_d = high_bits(table_read_word); // see (RULE6)
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tbl_ptr_q <= scr_pkg::TBL_PTR_RESET;
    end else if (clk_en) begin
      tbl_ptr_q <= tbl_ptr_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------------------
  always_comb begin
    regs.rdata = '0;
    if (ctrl_sel) begin
      regs.rdata = ctrl_q; // see (RULE1) see (RULE7)
    end else if (ptr_sel) begin
      regs.rdata = widen_ptr(tbl_ptr_q); // see (RULE6)
    end
  end

  // ---------------------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------------------
  // Straight from the register so a write takes effect at the commit edge
  assign serial_bus_clock_enable = ctrl_q[scr_pkg::BIT_SERIAL_CLK_EN]; // see (RULE2)
  assign minus_line_pullup_enable = ctrl_q[scr_pkg::BIT_MINUS_PULLUP]; // see (RULE3)
  // Only meaningful with an external oscillator; the clock tree decides whether to obey
  assign system_clock_rate_select = ctrl_q[scr_pkg::BIT_RATE_SELECT]; // see (RULE4)
  assign legacy_mouse_mode_flag = ctrl_q[scr_pkg::BIT_LEGACY_MODE]; // see (RULE5)

endmodule // scr_system_clock_ctrl

// file: test/scr_system_clock_ctrl_monitor.sv
// Concurrent checks on the clock control block ports
`timescale 1ns/1ns
module scr_system_clock_ctrl_monitor (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic table_read_valid,
  input wire logic [13:0] table_read_word,
  input wire logic serial_bus_clock_enable,
  input wire logic minus_line_pullup_enable,
  input wire logic system_clock_rate_select,
  input wire logic legacy_mouse_mode_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic wr_c;
  logic rd_done;
  logic [3:0] outs;
  assign wr_c = avs_write && !avs_waitrequest && avs_address == 8'h70 && avs_byteenable[0];
  assign rd_done = avs_read && !avs_waitrequest;
  assign outs = {legacy_mouse_mode_flag, system_clock_rate_select, minus_line_pullup_enable, serial_bus_clock_enable};
  AST_ENGINE_CLK: assert property (wr_c |=> serial_bus_clock_enable == $past(avs_writedata[3]))
    else $error("engine clock bit");
  AST_PULLUP: assert property (wr_c |=> minus_line_pullup_enable == $past(avs_writedata[4]))
    else $error("pull-up bit");
  AST_RATE: assert property (wr_c |=> system_clock_rate_select == $past(avs_writedata[6]))
    else $error("rate bit");
  AST_LEGACY: assert property (wr_c |=> legacy_mouse_mode_flag == $past(avs_writedata[7]))
    else $error("mode flag bit");
  // Outputs may only move on a completed write to the control byte
  AST_HOLD: assert property (!wr_c |=> $stable(outs))
    else $error("control output moved");
  AST_READBACK: assert property (rd_done && avs_address == 8'h70 |->
    {avs_readdata[7:6], avs_readdata[4:3]} == outs)
    else $error("readback differs");
  AST_PTR_BITS: assert property (rd_done && avs_address == 8'h7c |-> avs_readdata[7:3] == 5'h0)
    else $error("pointer high bits");
  AST_UPPER: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper lanes");
  AST_ONE_WAIT: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en |=>
    !avs_waitrequest || !clk_en)
    else $error("no answer");
  // First cycle after any reset release must show the cleared register state
  AST_RESET_CLEAR: assert property ($fell(sys_rst) |-> outs == 4'h0 && avs_readdata == 32'h0)
    else $error("state not cleared by reset");
endmodule // scr_system_clock_ctrl_monitor

bind scr_system_clock_ctrl scr_system_clock_ctrl_monitor scr_system_clock_ctrl_monitor_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .table_read_valid(table_read_valid), .table_read_word(table_read_word),
  .serial_bus_clock_enable(serial_bus_clock_enable), .minus_line_pullup_enable(minus_line_pullup_enable),
  .system_clock_rate_select(system_clock_rate_select), .legacy_mouse_mode_flag(legacy_mouse_mode_flag)
);

// file: test/scr_system_clock_ctrl_test.sv
// Self-checking bench for the clock control register block
`timescale 1ns/1ns
module scr_system_clock_ctrl_test;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] avs_address = 8'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic table_read_valid = 1'b0;
  logic [13:0] table_read_word = 14'h0;
  wire [3:0] outs;
  logic [31:0] rd;
  int n_mismatch = 0;
  int num_checks = 0;
  scr_system_clock_ctrl scr_system_clock_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .table_read_valid(table_read_valid), .table_read_word(table_read_word),
    .serial_bus_clock_enable(outs[0]), .minus_line_pullup_enable(outs[1]),
    .system_clock_rate_select(outs[2]), .legacy_mouse_mode_flag(outs[3]));
  always #50 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Leading edge wait keeps a released strobe from being raised in the same step
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic ctrl_is(input logic [7:0] e);
    acc(1'b0, 8'h70, 32'h0, 4'hf);
    chk(rd, {24'h0, e});
    chk({28'h0, outs}, {28'h0, e[7:6], e[4:3]});
  endtask
  task automatic ptr_is(input logic [31:0] e);
    acc(1'b0, 8'h7c, 32'h0, 4'hf);
    chk(rd, e);
  endtask
  task automatic tbl(input logic [13:0] w);
    @(posedge sys_clk);
    table_read_valid <= 1'b1;
    table_read_word <= w;
    @(posedge sys_clk);
    table_read_valid <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    ctrl_is(8'h00);
    ptr_is(32'h0);
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 8'h70, 32'hffff_ff00 | (32'h1 << i), 4'hf);
      ctrl_is(8'h1 << i);
    end
    acc(1'b1, 8'h70, 32'hff, 4'he);
    acc(1'b1, 8'h71, 32'h5a, 4'hf);
    acc(1'b1, 8'h7c, 32'h5a, 4'hf);
    acc(1'b1, 8'h40, 32'h5a, 4'hf);
    ctrl_is(8'h80);
    ptr_is(32'h0);
    acc(1'b0, 8'h40, 32'h0, 4'hf);
    chk(rd, 32'h0);
    tbl(14'h0500);
    ptr_is(32'h5);
    tbl(14'h3aff);
    ptr_is(32'h2);
    // Frozen clock enable must stall the access and leave the outputs alone
    clk_en <= 1'b0;
    fork
      acc(1'b1, 8'h70, 32'h6d, 4'hf);
      begin
        repeat (6) @(posedge sys_clk);
        chk({31'h0, avs_waitrequest}, 32'h1);
        chk({28'h0, outs}, 32'h8);
        clk_en <= 1'b1;
      end
    join
    ctrl_is(8'h6d);
    tbl(14'h0700);
    ptr_is(32'h7);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    ctrl_is(8'h00);
    ptr_is(32'h0);
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up();
  end
endmodule // scr_system_clock_ctrl_test
